// ==== exec_pkg.sv ====
package exec_pkg;

  // Opcode patterns and masks for the three instructions handled here.
  localparam logic [15:0] TSKIP_MASK    = 16'hFF00;
  localparam logic [15:0] TSKIP_CODE    = 16'h3300;
  localparam logic [15:0] TLWRITE_MASK  = 16'hFC00;
  localparam logic [15:0] TLWRITE_CODE  = 16'hA400;
  localparam logic [15:0] RLC_MASK      = 16'hFE00;
  localparam logic [15:0] RLC_CODE      = 16'h1A00;
  localparam int          SEL_BIT       = 9;
  localparam int          DEST_BIT      = 8;
  localparam int          MSB_BIT       = 7;

  // Reset values.
  localparam logic [7:0]  BYTE_RESET    = 8'h00;
  localparam logic [15:0] INSTR_RESET   = 16'h0000;

  // Phase within one instruction cycle.
  typedef enum logic [1:0] {
    PH_Q1,
    PH_Q2,
    PH_Q3,
    PH_Q4
  } phase_e;

  // Instruction kind after decode.
  typedef enum logic [1:0] {
    OP_OTHER,
    OP_TSKIP,
    OP_TLWRITE,
    OP_RLC
  } op_e;

  // Request toward the file register array.
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } file_req_s;

endpackage

// ==== table_latch_and_skip_exec.sv ====
// Summary of operation
// - Test-and-skip discards the prefetched next instruction when the file register is zero.
// - The discarded slot runs as a no-operation cycle doing nothing in every phase.
// - Test-and-skip takes one cycle without skip, two when the skip is taken.
// - Test-and-skip decodes from its leading opcode byte, low byte is file address.
// - Test-and-skip decodes in Q1, reads in Q2, processes in Q3, writes nothing.
// - Table latch write decodes from its opcode bits with select and don't-care bits.
// - Select one writes the high table latch byte, select zero the low byte.
// - Rotate left through carry reads in Q2, processes in Q3, writes in Q4.
// - Rotate destination zero writes working register; old bit 7 to carry, carry to 0.
module table_latch_and_skip_exec
  import exec_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // Instruction stream, one word taken at each Q1.
  input  wire logic [15:0] instr_in,
  // File register read data, valid in Q2.
  input  wire logic [7:0]  file_data_in,
  // File register access.
  output file_req_s        file_req_out,
  // Architectural results.
  output logic [15:0]      table_latch_out,
  output logic [7:0]       working_register_out,
  output logic             carry_out,
  // Cycle status.
  output phase_e           phase_out,
  output logic             nop_cycle_out,
  output logic             skip_out
);

  // Internal state and decode.
  phase_e      phase;
  op_e         op;
  logic [15:0] instr;
  logic [7:0]  operand;
  logic [7:0]  result;
  logic        result_carry;
  logic        squash;
  logic [7:0]  table_latch_high_byte;
  logic [7:0]  table_latch_low_byte;
  logic [7:0]  working_register;
  logic        carry;
  file_req_s   next_req;
  op_e         next_op;
  logic [7:0]  rotated;
  logic        skip_taken;

  // Four phases per instruction cycle.
  // The phases run free from reset with no stall, so every slot is exactly four clocks.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      phase <= PH_Q1;
    end else begin
      case (phase)
        PH_Q1:   phase <= PH_Q2;
        PH_Q2:   phase <= PH_Q3;
        PH_Q3:   phase <= PH_Q4;
        PH_Q4:   phase <= PH_Q1;
        default: phase <= PH_Q1;
      endcase
    end
  end

  // Decode from the raw word; a squashed slot decodes as nothing at all.
  always_comb begin
    if (squash) begin
      next_op = OP_OTHER;
    end else if ((instr_in & TSKIP_MASK) == TSKIP_CODE) begin
      next_op = OP_TSKIP;
    end else if ((instr_in & TLWRITE_MASK) == TLWRITE_CODE) begin
      next_op = OP_TLWRITE;
    end else if ((instr_in & RLC_MASK) == RLC_CODE) begin
      next_op = OP_RLC;
    end else begin
      next_op = OP_OTHER;
    end
  end

  // Latch the instruction and its decode in Q1.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      instr <= INSTR_RESET;
      op    <= OP_OTHER;
    end else if (phase == PH_Q1) begin
      instr <= instr_in;
      op    <= next_op;
    end
  end

  // Capture the operand in Q2 and process it in Q3.
  // Unknown words leave operand and result alone, so nothing downstream moves.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      operand      <= BYTE_RESET;
      result       <= BYTE_RESET;
      result_carry <= 1'b0;
    end else if (phase == PH_Q2 && op != OP_OTHER) begin
      operand <= file_data_in;
    end else if (phase == PH_Q3 && op != OP_OTHER) begin
      result       <= rotated;
      result_carry <= operand[MSB_BIT];
    end
  end

  // Rotated byte taken straight from the captured operand, so the Q4 file write
  // carries this instruction's result and not the one left in result by the last decoded instruction.
  assign rotated = {operand[6:0], carry};

  // The dropped slot is marked in the test's Q4 and in the Q1 after it, while op still holds the test; squash alone
  // stays set through the dropped slot and would stretch the mark over two slots.
  assign skip_taken = squash && (op == OP_TSKIP);

  // Skip decision: the zero test in Q3 squashes the slot that follows.
  // The next word is already fetched, so it is dropped rather than stalled.
  // Any other slot clears it in Q4, the dropped slot itself included.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      squash <= 1'b0;
    end else if (phase == PH_Q3 && op == OP_TSKIP) begin
      squash <= (operand == BYTE_RESET);
    end else if (phase == PH_Q4 && op != OP_TSKIP) begin
      squash <= 1'b0;
    end
  end

  // Table latch writes land in Q4, one byte only.
  // Leaving the other byte alone lets software fill the latch in two steps.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      table_latch_high_byte <= BYTE_RESET;
      table_latch_low_byte  <= BYTE_RESET;
    end else if (phase == PH_Q4 && op == OP_TLWRITE) begin
      if (instr[SEL_BIT]) begin
        table_latch_high_byte <= operand;
      end else begin
        table_latch_low_byte <= operand;
      end
    end
  end

  // Rotate writes its destination and carry in Q4.
  // With the destination bit set only carry changes here; the byte leaves on the file port.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      working_register <= BYTE_RESET;
      carry            <= 1'b0;
    end else if (phase == PH_Q4 && op == OP_RLC) begin
      carry <= result_carry;
      if (!instr[DEST_BIT]) begin
        working_register <= result;
      end
    end
  end

  // File port request for the phase about to begin.
  // Reads are raised one clock ahead so the data is back by the Q2 edge.
  always_comb begin
    next_req      = '0;
    next_req.addr = instr[7:0];
    next_req.data = result;
    if (phase == PH_Q1 && next_op != OP_OTHER) begin
      next_req.rd   = 1'b1;
      next_req.addr = instr_in[7:0];
    end else if (phase == PH_Q3 && op == OP_RLC && instr[DEST_BIT]) begin
      next_req.wr   = 1'b1;
      next_req.data = rotated;
    end
  end

  // File request register, aligned to the phase it serves.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      file_req_out <= '0;
    end else begin
      file_req_out <= next_req;
    end
  end

  // The no-operation mark loads at the Q4 edge, so it covers the
  // four phases of the dropped slot and nothing beyond them.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      nop_cycle_out <= 1'b0;
    end else if (phase == PH_Q4) begin
      nop_cycle_out <= skip_taken;
    end
  end

  // Every output comes straight from a flip-flop, so each
  // architectural value shows one clock after it is written inside.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      table_latch_out <= {BYTE_RESET, BYTE_RESET};
    end else begin
      table_latch_out <= {table_latch_high_byte, table_latch_low_byte};
    end
  end

  // Working register and carry mirrors.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      working_register_out <= BYTE_RESET;
      carry_out            <= 1'b0;
    end else begin
      working_register_out <= working_register;
      carry_out            <= carry;
    end
  end

  // Phase and squash mirrors for the fetch side.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      phase_out <= PH_Q1;
      skip_out  <= 1'b0;
    end else begin
      phase_out <= phase;
      skip_out  <= squash;
    end
  end

endmodule

// ==== exec_chk_sva.sv ====
module exec_chk
  import exec_pkg::*;
(
  // Clock, reset and watched ports.
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic [7:0]  file_data_in,
  input wire file_req_s   file_req_out,
  input wire logic [15:0] table_latch_out,
  input wire logic [7:0]  working_register_out,
  input wire phase_e      phase_out,
  input wire logic        nop_cycle_out
);
  // One clock domain, so clocking and reset are declared once.
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  chk_phase_step: assert property ($changed(phase_out) |-> phase_out == phase_e'($past(phase_out) + 2'h1))
    else $error("phase skipped a step");
  chk_read_pulse: assert property (file_req_out.rd |=> !file_req_out.rd && !file_req_out.wr)
    else $error("file read longer than one cycle");
  chk_write_slot: assert property (file_req_out.wr |-> $past(file_req_out.rd, 2))
    else $error("file write not two cycles after read");
  chk_write_data: assert property (file_req_out.wr |-> file_req_out.data[7:1] == $past(file_data_in[6:0], 2))
    else $error("rotated file data wrong");
  chk_nop_quiet: assert property (nop_cycle_out |-> !file_req_out.rd && !file_req_out.wr)
    else $error("squashed slot touched the file");
  chk_nop_length: assert property ($rose(nop_cycle_out) |-> nop_cycle_out [*4] ##1 !nop_cycle_out)
    else $error("squashed slot not one cycle long");
  // A table write may touch only one byte, and only with the data just read.
  chk_latch_byte: assert property ($changed(table_latch_out[15:8]) |-> $stable(table_latch_out[7:0]))
    else $error("both latch bytes changed");
  chk_latch_data: assert property ($changed(table_latch_out) |-> $past(file_req_out.rd, 4)
    && (table_latch_out[15:8] == $past(file_data_in, 4) || table_latch_out[7:0] == $past(file_data_in, 4)))
    else $error("latch byte not the file data");
  chk_work_data: assert property ($changed(working_register_out)
    |-> working_register_out[7:1] == $past(file_data_in[6:0], 4))
    else $error("working register not rotated data");
endmodule

bind table_latch_and_skip_exec exec_chk i_exec_chk (.*);

// ==== table_latch_and_skip_exec_tb.sv ====
module table_latch_and_skip_exec_tb
  import exec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_in, rst_in, carry_out, nop_cycle_out, skip_out;
  logic [15:0] instr_in, table_latch_out;
  logic [7:0]  file_data_in, working_register_out;
  file_req_s   file_req_out;
  phase_e      phase_out;
  int          n_mismatch, compares;

  table_latch_and_skip_exec i_table_latch_and_skip_exec (.*);

  // Free-running 25 MHz core clock.
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    compares++;
    if (seen !== want) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask

  // One instruction slot is four clocks; it is taken one edge after driving.
  task automatic run(input logic [15:0] code, input logic [7:0] data);
    instr_in <= code;
    file_data_in <= data;
    repeat (4) @(posedge clk_in);
  endtask

  task automatic test_latch();
    logic [15:0] want;
    want = 16'h0000;
    for (int k = 0; k < 4; k++) begin
      run(16'hA420 + 16'(k) * 16'h0100, 8'hB7 + 8'(k));
      run(16'h0000, 8'h00);
      if (k < 2) want[7:0] = 8'hB7 + 8'(k);
      else want[15:8] = 8'hB7 + 8'(k);
      check(table_latch_out, want);
      check(16'(carry_out), 16'h0000);
    end
  endtask

  task automatic test_rotate();
    run(16'h1A40, 8'hE6);
    run(16'h0000, 8'h00);
    check(16'(working_register_out), 16'h00CC);
    check(16'(carry_out), 16'h0001);
    run(16'h1A40, 8'h80);
    run(16'h1B40, 8'h01);
    run(16'h0000, 8'h00);
    check(16'(working_register_out), 16'h0001);
  endtask

  // Zero skips the write behind it, non-zero lets it run.
  task automatic test_skip();
    run(16'h3320, 8'h00);
    instr_in <= 16'hA430;
    file_data_in <= 8'h55;
    repeat (2) @(posedge clk_in);
    // Look mid-slot and off the edge while the dropped slot runs.
    @(negedge clk_in);
    check(16'(nop_cycle_out), 16'h0001);
    check(16'(skip_out), 16'h0001);
    check(16'(phase_out), 16'(PH_Q2));
    repeat (2) @(posedge clk_in);
    run(16'h0000, 8'h00);
    check(table_latch_out, 16'hBAB8);
    check(16'(nop_cycle_out), 16'h0000);
    run(16'h3320, 8'h01);
    run(16'hA430, 8'h55);
    check(16'(nop_cycle_out), 16'h0000);
    check(16'(skip_out), 16'h0000);
    run(16'h0000, 8'h00);
    check(table_latch_out, 16'hBA55);
  endtask

  task automatic summarize();
    if (n_mismatch == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Main sequence; the first slot is driven on the release edge.
  initial begin
    rst_in = 1'b1;
    instr_in = 16'h0000;
    file_data_in = 8'h00;
    n_mismatch = 0;
    compares = 0;
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    check(table_latch_out, 16'h0000);
    test_latch();
    test_rotate();
    test_skip();
    summarize();
  end

  // The tests need about 3.3 us; a hang is cut off well past that.
  initial begin
    #10000;
    n_mismatch++;
    summarize();
  end
endmodule
